//--- hpcd_pkg.sv
package hpcd_pkg;

  // timing of the decode update strobe
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SYMBOL_NS     = 648;
  localparam int unsigned SYMBOL_CYC    =
    (SYMBOL_NS / CLK_PERIOD_NS) < 1 ? 1 : (SYMBOL_NS / CLK_PERIOD_NS);

  localparam int unsigned NUM_CH = 2;

  // register byte offsets
  localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
  localparam logic [7:0] REG_SW_CFG_OFS = 8'h04;
  localparam logic [7:0] REG_PINS_OFS   = 8'h08;
  localparam logic [7:0] REG_ACTIVE_OFS = 8'h0c;
  localparam logic [7:0] REG_EVENT_OFS  = 8'h10;

  // control register fields and reset values
  localparam int unsigned CTRL_HW_MODE_POS = 0;
  localparam int unsigned CTRL_FREEZE_POS  = 1;
  localparam logic [1:0]  CTRL_RESET       = 2'h1;

  // configuration vector layout, shared by pins, software and active copy
  localparam int unsigned CFG_W        = 14;
  localparam int unsigned CFG_PAT_POS  = 0;
  localparam int unsigned CFG_LOOP_POS = 4;
  localparam int unsigned CFG_GAIN_POS = 8;
  localparam int unsigned CFG_JA_POS   = 10;
  localparam int unsigned CFG_HIZ_POS  = 12;
  localparam int unsigned CFG_EDGE_POS = 13;
  localparam logic [CFG_W-1:0] CFG_RESET = 14'h0000;

  // jitter attenuator elastic store depths in bits
  localparam logic [7:0] JA_FIFO_BROAD  = 8'h40;
  localparam logic [7:0] JA_FIFO_NARROW = 8'h80;
  localparam logic [7:0] JA_FIFO_NONE   = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TX_NORMAL     = 2'h0,
    TX_ALL_ONES   = 2'h1,
    TX_PRBS       = 2'h2,
    TX_POWER_DOWN = 2'h3
  } hpcd_tx_src_t;

  typedef enum logic [1:0] {
    LOOP_NONE    = 2'h0,
    LOOP_ANALOG  = 2'h1,
    LOOP_DIGITAL = 2'h2,
    LOOP_REMOTE  = 2'h3
  } hpcd_loop_t;

  typedef enum logic [1:0] {
    JA_OFF       = 2'h0,
    JA_RX_BROAD  = 2'h1,
    JA_RX_NARROW = 2'h2,
    JA_TX_NARROW = 2'h3
  } hpcd_ja_t;

endpackage

//--- hpcd_pin_sync.sv
module hpcd_pin_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] chk_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
      chk_ff  <= '0;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      chk_ff  <= sync_ff;
    end
  end

  // a bit changes only once second and third stages agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          pin_out[i] <= 1'b0;
        else if (sync_ff[i] == chk_ff[i])
          pin_out[i] <= chk_ff[i];
      end
    end
  endgenerate

endmodule

//--- hpcd_chan.sv
module hpcd_chan
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       apply,
  input  wire logic [1:0] pattern_sel,
  input  wire logic [1:0] loop_sel,
  input  wire logic       gain_sel,
  output logic      [1:0] tx_source,
  output logic            tx_power_down,
  output logic      [1:0] loopback_mode,
  output logic            monitor_gain_26db
);

  hpcd_pkg::hpcd_tx_src_t src;
  logic                   pd;

  always_comb
  begin
    src = hpcd_pkg::hpcd_tx_src_t'(pattern_sel);
    pd  = 1'b0;
    unique case (src)
      hpcd_pkg::TX_NORMAL:     pd = 1'b0;
      hpcd_pkg::TX_ALL_ONES:   pd = 1'b0;
      hpcd_pkg::TX_PRBS:       pd = 1'b0;
      hpcd_pkg::TX_POWER_DOWN: pd = 1'b1;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_source         <= hpcd_pkg::TX_NORMAL;
      tx_power_down     <= 1'b0;
      loopback_mode     <= hpcd_pkg::LOOP_NONE;
      monitor_gain_26db <= 1'b0;
    end
    else if (apply)
    begin
      tx_source         <= src;
      tx_power_down     <= pd;
      loopback_mode     <= loop_sel;
      monitor_gain_26db <= gain_sel;
    end
  end

endmodule

//--- hpcd_top.sv
// Summary of operation
// - pattern select: normal, ones, PRBS, transmitter off
// - attenuator select 00 bypasses attenuator entirely
// - select 01: receive path, broad, 64-bit FIFO
// - select 10: receive path, narrow, 128-bit FIFO
// - select 11: transmit path, narrow, 128-bit FIFO
// - monitor gain select: low 0 dB, high 26 dB
// - loopback select: none, analog, digital, remote
// - no in-band loopback under pin control
// - high-impedance input high disables both drivers
// - edge select: low rising, high falling
module hpcd_top
#(
  parameter int unsigned SYMBOL_CYC = hpcd_pkg::SYMBOL_CYC
)
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [1:0][1:0] tx_pattern_select,
  input  wire logic [1:0][1:0] loopback_select,
  input  wire logic [1:0]      monitor_gain_select,
  input  wire logic [1:0]      jitter_atten_select,
  input  wire logic            driver_hiz_enable,
  input  wire logic            rx_clock_edge_select,
  output logic      [1:0][1:0] tx_source,
  output logic      [1:0]      tx_power_down,
  output logic      [1:0][1:0] loopback_mode,
  output logic      [1:0]      monitor_gain_26db,
  output logic                 ja_enable,
  output logic                 ja_in_rx_path,
  output logic                 ja_in_tx_path,
  output logic                 ja_narrow_bw,
  output logic      [7:0]      ja_fifo_depth,
  output logic      [1:0]      driver_enable,
  output logic                 rclk_falling_active,
  output logic                 inband_loop_avail,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic [2:0]      s_axi_awprot,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic      [1:0]      s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic [2:0]      s_axi_arprot,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic      [31:0]     s_axi_rdata,
  output logic      [1:0]      s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready
);

  localparam int unsigned W = hpcd_pkg::CFG_W;

  logic [W-1:0]  pin_raw;
  logic [W-1:0]  pin_sync;
  logic [W-1:0]  sel_cfg;
  logic [W-1:0]  sw_cfg_ff;
  logic [W-1:0]  active_cfg_ff;
  logic [1:0]    ctrl_ff;
  logic          event_ff;
  logic [15:0]   div_ff;
  logic          sym_tick;
  logic          apply;
  logic          hw_mode;

  logic          aw_hold_ff;
  logic          w_hold_ff;
  logic [7:0]    awaddr_ff;
  logic [31:0]   wdata_ff;
  logic [3:0]    wstrb_ff;
  logic          do_write;
  logic          do_read;
  logic [31:0]   rd_mux;
  logic          rd_hit;
  logic          wr_hit;
  logic          event_clr;

  assign pin_raw = {rx_clock_edge_select, driver_hiz_enable,
                    jitter_atten_select, monitor_gain_select,
                    loopback_select, tx_pattern_select};

  hpcd_pin_sync #(
    .WIDTH (W)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (pin_raw),
    .pin_out (pin_sync)
  );

  // symbol-rate strobe so settings switch only between symbols
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_ff <= 16'h0000;
    else if (div_ff >= 16'(SYMBOL_CYC - 1))
      div_ff <= 16'h0000;
    else
      div_ff <= div_ff + 16'h0001;
  end

  assign sym_tick = (div_ff == 16'h0000);
  assign hw_mode  = ctrl_ff[hpcd_pkg::CTRL_HW_MODE_POS];
  assign apply    = sym_tick & ~ctrl_ff[hpcd_pkg::CTRL_FREEZE_POS];
  assign sel_cfg  = hw_mode ? pin_sync : sw_cfg_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      active_cfg_ff <= hpcd_pkg::CFG_RESET;
    else if (apply)
      active_cfg_ff <= sel_cfg;
  end

  genvar c;
  generate
    for (c = 0; c < hpcd_pkg::NUM_CH; c++)
    begin : g_ch
      hpcd_chan u_chan (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .apply             (apply),
        .pattern_sel       (sel_cfg[hpcd_pkg::CFG_PAT_POS + 2*c +: 2]),
        .loop_sel          (sel_cfg[hpcd_pkg::CFG_LOOP_POS + 2*c +: 2]),
        .gain_sel          (sel_cfg[hpcd_pkg::CFG_GAIN_POS + c]),
        .tx_source         (tx_source[c]),
        .tx_power_down     (tx_power_down[c]),
        .loopback_mode     (loopback_mode[c]),
        .monitor_gain_26db (monitor_gain_26db[c])
      );
    end
  endgenerate

  // global attenuator placement, one setting for both channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ja_enable     <= 1'b0;
      ja_in_rx_path <= 1'b0;
      ja_in_tx_path <= 1'b0;
      ja_narrow_bw  <= 1'b0;
      ja_fifo_depth <= hpcd_pkg::JA_FIFO_NONE;
    end
    else if (apply)
    begin
      unique case (hpcd_pkg::hpcd_ja_t'(sel_cfg[hpcd_pkg::CFG_JA_POS +: 2]))
        hpcd_pkg::JA_OFF:
        begin
          ja_enable     <= 1'b0;
          ja_in_rx_path <= 1'b0;
          ja_in_tx_path <= 1'b0;
          ja_narrow_bw  <= 1'b0;
          ja_fifo_depth <= hpcd_pkg::JA_FIFO_NONE;
        end
        hpcd_pkg::JA_RX_BROAD:
        begin
          ja_enable     <= 1'b1;
          ja_in_rx_path <= 1'b1;
          ja_in_tx_path <= 1'b0;
          ja_narrow_bw  <= 1'b0;
          ja_fifo_depth <= hpcd_pkg::JA_FIFO_BROAD;
        end
        hpcd_pkg::JA_RX_NARROW:
        begin
          ja_enable     <= 1'b1;
          ja_in_rx_path <= 1'b1;
          ja_in_tx_path <= 1'b0;
          ja_narrow_bw  <= 1'b1;
          ja_fifo_depth <= hpcd_pkg::JA_FIFO_NARROW;
        end
        hpcd_pkg::JA_TX_NARROW:
        begin
          ja_enable     <= 1'b1;
          ja_in_rx_path <= 1'b0;
          ja_in_tx_path <= 1'b1;
          ja_narrow_bw  <= 1'b1;
          ja_fifo_depth <= hpcd_pkg::JA_FIFO_NARROW;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      driver_enable       <= 2'h3;
      rclk_falling_active <= 1'b0;
    end
    else if (apply)
    begin
      driver_enable <= {2{~sel_cfg[hpcd_pkg::CFG_HIZ_POS]}};
      rclk_falling_active <= sel_cfg[hpcd_pkg::CFG_EDGE_POS];
    end
  end

  // in-band loopback exists only under software control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      inband_loop_avail <= 1'b0;
    else
      inband_loop_avail <= ~hw_mode;
  end

  // configuration change event, set wins over write-one-to-clear
  assign event_clr = do_write && wr_hit && wstrb_ff[0] && wdata_ff[0]
                     && (awaddr_ff == hpcd_pkg::REG_EVENT_OFS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      event_ff <= 1'b0;
    else
      event_ff <= (event_ff & ~event_clr) |
                  (apply && (sel_cfg != active_cfg_ff));
  end

  // write channel: address and data taken in either order
  assign s_axi_awready = ~aw_hold_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_ff & ~s_axi_bvalid;
  assign do_write      = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
  assign wr_hit        = (awaddr_ff == hpcd_pkg::REG_CTRL_OFS)   ||
                         (awaddr_ff == hpcd_pkg::REG_SW_CFG_OFS) ||
                         (awaddr_ff == hpcd_pkg::REG_EVENT_OFS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= {s_axi_awaddr[7:2], 2'h0};
      end
      else if (do_write)
        aw_hold_ff <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      else if (do_write)
        w_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= hpcd_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? hpcd_pkg::RESP_OKAY : hpcd_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff   <= hpcd_pkg::CTRL_RESET;
      sw_cfg_ff <= hpcd_pkg::CFG_RESET;
    end
    else if (do_write)
    begin
      if (awaddr_ff == hpcd_pkg::REG_CTRL_OFS && wstrb_ff[0])
        ctrl_ff <= wdata_ff[1:0];
      if (awaddr_ff == hpcd_pkg::REG_SW_CFG_OFS)
      begin
        if (wstrb_ff[0])
          sw_cfg_ff[7:0] <= wdata_ff[7:0];
        if (wstrb_ff[1])
          sw_cfg_ff[W-1:8] <= wdata_ff[W-1:8];
      end
    end
  end

  // read channel: one read at a time, unmapped answers SLVERR
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_read       = s_axi_arvalid & s_axi_arready;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'h0})
      hpcd_pkg::REG_CTRL_OFS:   rd_mux[1:0]   = ctrl_ff;
      hpcd_pkg::REG_SW_CFG_OFS: rd_mux[W-1:0] = sw_cfg_ff;
      hpcd_pkg::REG_PINS_OFS:   rd_mux[W-1:0] = pin_sync;
      hpcd_pkg::REG_ACTIVE_OFS: rd_mux[W-1:0] = active_cfg_ff;
      hpcd_pkg::REG_EVENT_OFS:  rd_mux[0]     = event_ff;
      default:                  rd_hit        = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= hpcd_pkg::RESP_OKAY;
    end
    else if (do_read)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? hpcd_pkg::RESP_OKAY : hpcd_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

//--- hpcd_props.sv
module hpcd_props
#(
  parameter int unsigned SYMBOL_CYC = 2
)
(
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic [1:0]      monitor_gain_select,
  input wire logic            driver_hiz_enable,
  input wire logic            rx_clock_edge_select,
  input wire logic [1:0][1:0] tx_source,
  input wire logic [1:0]      tx_power_down,
  input wire logic [1:0]      monitor_gain_26db,
  input wire logic            ja_enable,
  input wire logic            ja_in_rx_path,
  input wire logic            ja_in_tx_path,
  input wire logic            ja_narrow_bw,
  input wire logic [7:0]      ja_fifo_depth,
  input wire logic [1:0]      driver_enable,
  input wire logic            rclk_falling_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // three sync stages, one agree cycle, then up to a full symbol
  localparam logic [15:0] SETTLE = 16'(SYMBOL_CYC + 3);

  logic [3:0]  pins_now;
  logic [3:0]  prev_ff;
  logic [15:0] quiet_ff;

  assign pins_now = {monitor_gain_select, driver_hiz_enable,
                     rx_clock_edge_select};

  // cycles since a watched pin last moved, saturating
  always_ff @(posedge aclk)
  begin
    prev_ff <= pins_now;
    if (!aresetn || (prev_ff != pins_now))
      quiet_ff <= 16'h0000;
    else if (quiet_ff != 16'hffff)
      quiet_ff <= quiet_ff + 16'h0001;
  end

  // a pin held this long has passed the synchroniser and a symbol tick
  sequence s_hiz;
    $stable(driver_hiz_enable)[*8] ##0 (quiet_ff >= SETTLE);
  endsequence
  sequence s_edge;
    $stable(rx_clock_edge_select)[*8] ##0 (quiet_ff >= SETTLE);
  endsequence
  sequence s_gain;
    $stable(monitor_gain_select)[*8] ##0 (quiet_ff >= SETTLE);
  endsequence

  property p_pd;
    tx_power_down == {tx_source[1] == 2'h3, tx_source[0] == 2'h3};
  endproperty
  property p_off;
    !ja_enable |-> ja_fifo_depth == 8'h00 && !ja_in_rx_path && !ja_in_tx_path;
  endproperty
  property p_broad;
    ja_in_rx_path && !ja_narrow_bw |-> ja_enable && ja_fifo_depth == 8'h40;
  endproperty
  property p_rxn;
    ja_in_rx_path && ja_narrow_bw |-> ja_fifo_depth == 8'h80 && !ja_in_tx_path;
  endproperty
  property p_tx;
    ja_in_tx_path |-> ja_enable && ja_narrow_bw && ja_fifo_depth == 8'h80;
  endproperty
  property p_hiz;
    s_hiz |-> driver_enable == {2{!driver_hiz_enable}};
  endproperty
  property p_edge;
    s_edge |-> rclk_falling_active == rx_clock_edge_select;
  endproperty
  property p_gain;
    s_gain |-> monitor_gain_26db == monitor_gain_select;
  endproperty

  a_pd: assert property (p_pd)
    else $error("power down flag disagrees with source");
  a_off: assert property (p_off)
    else $error("attenuator off but still placed");
  a_broad: assert property (p_broad)
    else $error("broad receive attenuator depth wrong");
  a_rxn: assert property (p_rxn)
    else $error("narrow receive attenuator depth wrong");
  a_tx: assert property (p_tx)
    else $error("transmit attenuator setting wrong");
  a_hiz: assert property (p_hiz)
    else $error("driver enable disagrees with hiz pin");
  a_edge: assert property (p_edge)
    else $error("clock edge disagrees with pin");
  a_gain: assert property (p_gain)
    else $error("monitor gain disagrees with pin");
endmodule

bind hpcd_top hpcd_props #(.SYMBOL_CYC(SYMBOL_CYC)) i_hpcd_props (
  .aclk, .aresetn, .monitor_gain_select, .driver_hiz_enable,
  .rx_clock_edge_select, .tx_source, .tx_power_down, .monitor_gain_26db,
  .ja_enable, .ja_in_rx_path, .ja_in_tx_path, .ja_narrow_bw,
  .ja_fifo_depth, .driver_enable, .rclk_falling_active);

//--- hpcd_straps.sv
module hpcd_straps
(
  input  wire logic [13:0]     cfg,
  output logic      [1:0][1:0] pat,
  output logic      [1:0][1:0] loop,
  output logic      [1:0]      gain,
  output logic      [1:0]      jsel,
  output logic                 hiz,
  output logic                 edg
);
  timeunit 1ns;
  timeprecision 1ps;
  // board straps: static levels, changed only by the apply task
  assign pat  = cfg[3:0];
  assign loop = cfg[7:4];
  assign gain = cfg[9:8];
  assign jsel = cfg[11:10];
  assign hiz  = cfg[12];
  assign edg  = cfg[13];
endmodule

//--- tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 2;
  logic            aclk, aresetn, hiz, edg, jae, jar, jat, jan, rfa, ila;
  logic            awv, wv, arv, awr, wr_, bv, arr, rv;
  logic [1:0][1:0] pat, lsel, txs, lpm;
  logic [1:0]      gsel, jsel, pd, gn, de, rsp, brsp, rrsp;
  logic [7:0]      dep, awa, ara;
  logic [13:0]     cfg, cur, c;
  logic [31:0]     wd, rdata, dat, r;
  logic [26:0]     outv, seen;
  int              errors, checks;

  assign outv = {txs, pd, lpm, gn, jae, jar, jat, jan, dep, de, rfa};

  hpcd_straps i_hpcd_straps (.cfg(cfg), .pat(pat), .loop(lsel), .gain(gsel),
    .jsel(jsel), .hiz(hiz), .edg(edg));

  hpcd_top #(.SYMBOL_CYC(SC)) i_hpcd_top (.aclk(aclk), .aresetn(aresetn),
    .tx_pattern_select(pat), .loopback_select(lsel),
    .monitor_gain_select(gsel), .jitter_atten_select(jsel),
    .driver_hiz_enable(hiz), .rx_clock_edge_select(edg), .tx_source(txs),
    .tx_power_down(pd), .loopback_mode(lpm), .monitor_gain_26db(gn),
    .ja_enable(jae), .ja_in_rx_path(jar), .ja_in_tx_path(jat),
    .ja_narrow_bw(jan), .ja_fifo_depth(dep), .driver_enable(de),
    .rclk_falling_active(rfa), .inband_loop_avail(ila),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(brsp),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rrsp), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [26:0] expv(input logic [13:0] k);
    logic [1:0] j;
    j = k[11:10];
    expv = {k[3:0], k[3:2] == 2'h3, k[1:0] == 2'h3, k[7:4], k[9:8],
            j != 2'h0, j == 2'h1 || j == 2'h2, j == 2'h3, j[1],
            j == 2'h1 ? 8'h40 : (j == 2'h0 ? 8'h00 : 8'h80),
            {2{!k[12]}}, k[13]};
  endfunction

  task conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tk;
    n = 0;
    tk = 1'b0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!tk)
    begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wr_;
      tk = bv;
      rsp = brsp;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      n++;
      if (n > 99)
      begin
        errors++;
        conclude();
      end
    end
  endtask

  task rd(input logic [7:0] a);
    int n;
    logic ta, tk;
    n = 0;
    tk = 1'b0;
    ara <= a;
    arv <= 1'b1;
    while (!tk)
    begin
      @(negedge aclk);
      ta = arv && arr;
      tk = rv;
      dat = rdata;
      rsp = rrsp;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
      n++;
      if (n > 99)
      begin
        errors++;
        conclude();
      end
    end
  endtask

  // sample settled outputs mid-cycle, return on a rising edge
  task settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
    seen = outv;
    @(posedge aclk);
  endtask

  task apply(input logic [13:0] k);
    cfg <= k;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("hold", outv, expv(cur));
    settle(SC + 3);
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    conclude();
  end

  initial
  begin
    {aresetn, awv, wv, arv} = 4'h0;
    {awa, ara, wd, cfg, cur} = '0;
    r = 32'he0b0;
    errors = 0;
    checks = 0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("reset", outv, expv(14'h0));
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00);
    chk("ctrl", dat, 32'h1);
    chk("inband", ila, 1'b0);
    $display("reset test done");
    for (int i = 0; i < 24; i++)
    begin
      r = lfsr(r);
      c = (i < 4) ? {i[1], i[0], i[1:0], i[1:0], ~i[1:0], i[1:0],
                     2'h3 - i[1:0], i[1:0]} : r[13:0];
      apply(c);
      chk("decode", seen, expv(c));
      cur = c;
    end
    rd(8'h0c);
    chk("active", dat, {18'h0, cur});
    rd(8'h10);
    chk("event", dat, 32'h1);
    wr(8'h10, 32'h1);
    rd(8'h10);
    chk("event clear", dat, 32'h0);
    $display("decode test done");
    wr(8'h00, 32'h3);
    c = cur ^ 14'h0003;
    apply(c);
    chk("frozen", seen, expv(cur));
    rd(8'h08);
    chk("pins", dat, {18'h0, c});
    cur = c;
    wr(8'h00, 32'h1);
    settle(SC + 6);
    chk("thawed", seen, expv(cur));
    $display("freeze test done");
    c = {cur[13:12], ~cur[11:10], cur[9:8], ~cur[7:0]};
    wr(8'h04, {18'h0, c});
    rd(8'h04);
    chk("sw cfg", dat, {18'h0, c});
    wr(8'h00, 32'h0);
    settle(SC + 6);
    chk("software", seen, expv(c));
    chk("inband", ila, 1'b1);
    wr(8'h00, 32'h1);
    settle(SC + 6);
    chk("pin control", seen, expv(cur));
    chk("inband", ila, 1'b0);
    $display("mode test done");
    rd(8'h14);
    chk("unmapped resp", rsp, 2'h2);
    chk("unmapped data", dat, 32'h0);
    wr(8'h08, 32'h0);
    chk("read only resp", rsp, 2'h2);
    $display("bus error test done");
    conclude();
  end
endmodule
